/* design/adc_device.sv */
// compensation device: register file, embedded page and drift datapath
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"

// Behaviour
// - compensated = raw + sens/100 * ambient delta
// - sensitivity term is 16 times code plus 2048
// - boot restores signed sensitivity code default
// - host powers down before changing enable
// - page-open bit grants embedded page access
// - indirect read via direction, address, data
// - indirect write via direction, address, data
// - enable bit is 04h of config 28h
// - disable by ANDing config with FBh
// - write 01h to 2Ah resets algorithms
// - algorithm reset recaptures reference, keeps enable
// - host restarts acquisition after closing page
// - compensated result published at 38h/39h
// - raw bytes 26h/27h always uncompensated
// - disabled: compensated equals raw
// - algorithms take compensated samples when active
// - no compensation while gain is reduced
// - host passes custom sensitivity code as given, software rounds
// - gain field 000b reduces, 111b default
// - ambient is 100 LSB per degree
module adc_device
  import adc_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         resetn,
  adc_link_if.dev           link,
  input  wire logic [15:0]  raw_object_sample,
  input  wire logic [15:0]  ambient_sample,
  input  wire logic         sample_valid,
  output logic      [15:0]  algo_input,
  output logic              algo_restart,
  output logic              comp_active,
  output logic              acquisition_on
);

  adc_dev_state_t q;
  adc_dev_state_t n;

  // ---------------------------------------------------------------
  // derived controls
  // ---------------------------------------------------------------
  logic gain_reduced;
  logic page_open;
  logic comp_on;

  assign gain_reduced = (q.gain[`ADC_GAIN_LSB +: 3] == `ADC_GAIN_REDUCED);
  assign page_open    = q.page_ctrl[`ADC_OPEN_BIT];
  // gain reduction overrides a stale enable bit
  assign comp_on      = q.emb_config[`ADC_COMP_BIT] & ~gain_reduced;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  function automatic logic [7:0] emb_read(input adc_dev_state_t s);
    // reset register is write-only and reads zero
    if (s.page_addr == `ADC_EMB_CONFIG) begin
      return s.emb_config;
    end
    return 8'h00;
  endfunction

  function automatic logic [7:0] reg_read(input adc_dev_state_t s,
                                          input logic [7:0]     a,
                                          input logic           open);
    case (a)
      `ADC_REG_PAGE_ADDR: return s.page_addr;
      `ADC_REG_PAGE_DATA: begin
        if (open && s.page_dir[`ADC_DIR_READ_BIT]) begin
          return emb_read(s);
        end
        return s.page_data;
      end
      `ADC_REG_PAGE_DIR:  return s.page_dir;
      `ADC_REG_GAIN:      return s.gain;
      `ADC_REG_SENS:      return s.sens;
      `ADC_REG_RATE:      return s.rate;
      `ADC_REG_PAGE_CTRL: return s.page_ctrl;
      `ADC_REG_RAW_LO:    return s.raw[7:0];
      `ADC_REG_RAW_HI:    return s.raw[15:8];
      `ADC_REG_COMP_LO:   return s.comp[7:0];
      `ADC_REG_COMP_HI:   return s.comp[15:8];
      default:            return 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic signed [13:0] sens_term;
    logic signed [16:0] delta;
    logic signed [30:0] prod;
    logic signed [30:0] quot;
    logic signed [31:0] total;
    logic        [15:0] ref_now;
    logic        [15:0] sat;
    sens_term = 14'sh0000;
    delta     = 17'sh00000;
    prod      = 31'sh00000000;
    quot      = 31'sh00000000;
    total     = 32'sh00000000;
    ref_now   = q.ref_amb;
    sat       = 16'h0000;
    n            = q;
    n.algo_reset = 1'b0;
    n.rdata      = 8'h00;

    if (link.rd) begin
      n.rdata = reg_read(q, link.addr, page_open);
    end

    if (link.wr) begin
      case (link.addr)
        `ADC_REG_PAGE_ADDR: n.page_addr = link.wdata;
        `ADC_REG_PAGE_DATA: begin
          n.page_data = link.wdata;
          if (page_open && q.page_dir[`ADC_DIR_WRITE_BIT]) begin
            if (q.page_addr == `ADC_EMB_CONFIG) begin
              n.emb_config = gain_reduced ?
                             (link.wdata & `ADC_COMP_CLEAR) : link.wdata;
            end
            if (q.page_addr == `ADC_EMB_RESET &&
                link.wdata[`ADC_RESTART_BIT]) begin
              // reference is retaken on the next conversion
              n.algo_reset  = 1'b1;
              n.ref_pending = 1'b1;
            end
          end
        end
        `ADC_REG_PAGE_DIR:  n.page_dir = link.wdata;
        `ADC_REG_GAIN:      n.gain     = link.wdata;
        `ADC_REG_SENS:      n.sens     = link.wdata;
        `ADC_REG_RATE:      n.rate     = link.wdata;
        `ADC_REG_PAGE_CTRL: begin
          // page access only opens the window
          n.page_ctrl = link.wdata;
          n.page_ctrl[`ADC_BOOT_BIT] = 1'b0;
          if (link.wdata[`ADC_BOOT_BIT]) begin
            // reboot reloads trimmed defaults, rate is kept
            n.sens = `ADC_SENS_DEFAULT;
            n.gain = `ADC_GAIN_DEFAULT;
          end
        end
        default: ;
      endcase
    end

    if (sample_valid && acquisition_on) begin
      if (q.ref_pending) begin
        ref_now       = ambient_sample;
        n.ref_amb     = ambient_sample;
        n.ref_pending = 1'b0;
      end
      sens_term = $signed({{2{q.sens[7]}}, q.sens, 4'h0}) +
                  `ADC_SENS_OFFSET;
      // delta is in ambient units of 100 LSB per degree
      delta = $signed({ambient_sample[15], ambient_sample}) -
              $signed({ref_now[15], ref_now});
      prod  = sens_term * delta;
      quot  = prod / `ADC_AMB_PER_DEG;
      total = $signed({quot[30], quot}) +
              $signed({{16{raw_object_sample[15]}}, raw_object_sample});
      // clamp instead of wrapping so a big swing stays monotonic
      if (total > 32'sh00007fff) begin
        sat = 16'h7fff;
      end else if (total < -32'sh00008000) begin
        sat = 16'h8000;
      end else begin
        sat = total[15:0];
      end
      n.raw  = raw_object_sample;
      n.comp = comp_on ? sat : raw_object_sample;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      q             <= '0;
      q.sens        <= `ADC_SENS_DEFAULT;
      q.gain        <= `ADC_GAIN_DEFAULT;
      q.ref_pending <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.rdata     = q.rdata;
  assign algo_input     = q.comp;
  assign algo_restart   = q.algo_reset;
  assign comp_active    = comp_on;
  assign acquisition_on = (q.rate[3:0] != 4'h0);

endmodule
`default_nettype wire

/* common/adc_map.svh */
// register offsets, field positions and reset values for drift compensation
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

// ---------------------------------------------------------------
// device register map
// ---------------------------------------------------------------
`define ADC_REG_PAGE_ADDR  8'h08
`define ADC_REG_PAGE_DATA  8'h09
`define ADC_REG_PAGE_DIR   8'h11
`define ADC_REG_GAIN       8'h17
`define ADC_REG_SENS       8'h1d
`define ADC_REG_RATE       8'h20
`define ADC_REG_PAGE_CTRL  8'h21
`define ADC_REG_RAW_LO     8'h26
`define ADC_REG_RAW_HI     8'h27
`define ADC_REG_COMP_LO    8'h38
`define ADC_REG_COMP_HI    8'h39

// ---------------------------------------------------------------
// embedded page
// ---------------------------------------------------------------
`define ADC_EMB_CONFIG     8'h28
`define ADC_EMB_RESET      8'h2a
`define ADC_COMP_MASK      8'h04
`define ADC_COMP_CLEAR     8'hfb
`define ADC_RESTART_VAL    8'h01
`define ADC_COMP_BIT       2
`define ADC_RESTART_BIT    0

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define ADC_DIR_READ_BIT   0
`define ADC_DIR_WRITE_BIT  1
`define ADC_DIR_READ_VAL   8'h01
`define ADC_DIR_WRITE_VAL  8'h02
`define ADC_OPEN_BIT       4
`define ADC_OPEN_VAL       8'h10
`define ADC_BOOT_BIT       7
`define ADC_GAIN_LSB       4
`define ADC_GAIN_REDUCED   3'h0
`define ADC_GAIN_DEFAULT   8'hf1
`define ADC_SENS_DEFAULT   8'h00
`define ADC_SENS_OFFSET    14'sh0800
`define ADC_AMB_PER_DEG    31'sh64
`define ADC_POWER_DOWN     8'h00

// ---------------------------------------------------------------
// controller register map
// ---------------------------------------------------------------
`define ADC_HST_CMD        8'h00
`define ADC_HST_SENS       8'h04
`define ADC_HST_ODR        8'h08
`define ADC_HST_STATUS     8'h0c
`define ADC_HST_CONFIG     8'h10
`define ADC_CMD_ENABLE     0
`define ADC_CMD_DISABLE    1
`define ADC_CMD_SENS       2

`endif

/* common/adc_pkg.sv */
// types shared by the compensation device and its controller
package adc_pkg;

  typedef enum logic [1:0] {
    ADC_IDLE   = 2'b00,
    ADC_ISSUE  = 2'b01,
    ADC_SETTLE = 2'b10
  } adc_host_st_t;

  typedef struct packed {
    logic [7:0]  page_addr;
    logic [7:0]  page_data;
    logic [7:0]  page_dir;
    logic [7:0]  sens;
    logic [7:0]  gain;
    logic [7:0]  rate;
    logic [7:0]  page_ctrl;
    logic [7:0]  emb_config;
    logic [15:0] raw;
    logic [15:0] comp;
    logic [15:0] ref_amb;
    logic        ref_pending;
    logic        algo_reset;
    logic [7:0]  rdata;
  } adc_dev_state_t;

  typedef struct packed {
    adc_host_st_t st;
    logic [3:0]   step;
    logic         enable;
    logic [7:0]   sens_code;
    logic [7:0]   output_rate_field;
    logic [7:0]   cfg;
    logic         busy;
    logic         refused;
    logic         done;
    logic [7:0]   addr;
    logic [7:0]   wdata;
    logic         wr;
    logic         rd;
    logic [7:0]   sw_rdata;
  } adc_host_state_t;

endpackage

/* common/adc_link_if.sv */
// register port between controller and compensation device
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport ctl (output addr, output wdata, output wr, output rd,
               input rdata);
  modport dev (input addr, input wdata, input wr, input rd,
               output rdata);
endinterface
`default_nettype wire

/* design/adc_host.sv */
// controller end: runs the enable, disable and sensitivity sequences
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"

module adc_host
  import adc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  adc_link_if.ctl          link,
  input  wire logic [7:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [7:0]  sw_rdata
);

  adc_host_state_t q;
  adc_host_state_t n;

  // ---------------------------------------------------------------
  // step table: {write, read, address, data}
  // ---------------------------------------------------------------
  function automatic logic [17:0] step_op(input adc_host_state_t s,
                                          input logic [3:0]      k);
    logic [7:0] mod;
    mod = s.enable ? (s.cfg | `ADC_COMP_MASK)
                   : (s.cfg & `ADC_COMP_CLEAR);
    case (k)
      4'h0: return {2'b01, `ADC_REG_GAIN,      8'h00};
      4'h1: return {2'b10, `ADC_REG_RATE,      `ADC_POWER_DOWN};
      4'h2: return {2'b10, `ADC_REG_PAGE_CTRL, `ADC_OPEN_VAL};
      4'h3: return {2'b10, `ADC_REG_PAGE_DIR,  `ADC_DIR_READ_VAL};
      4'h4: return {2'b10, `ADC_REG_PAGE_ADDR, `ADC_EMB_CONFIG};
      4'h5: return {2'b01, `ADC_REG_PAGE_DATA, 8'h00};
      4'h6: return {2'b10, `ADC_REG_PAGE_DIR,  8'h00};
      4'h7: return {2'b10, `ADC_REG_PAGE_DIR,  `ADC_DIR_WRITE_VAL};
      4'h8: return {2'b10, `ADC_REG_PAGE_ADDR, `ADC_EMB_CONFIG};
      4'h9: return {2'b10, `ADC_REG_PAGE_DATA, mod};
      4'ha: return {2'b10, `ADC_REG_PAGE_ADDR, `ADC_EMB_RESET};
      4'hb: return {2'b10, `ADC_REG_PAGE_DATA, `ADC_RESTART_VAL};
      4'hc: return {2'b10, `ADC_REG_PAGE_DIR,  8'h00};
      4'hd: return {2'b10, `ADC_REG_PAGE_CTRL, 8'h00};
      4'he: return {2'b10, `ADC_REG_RATE,      s.output_rate_field};
      // integer code held as given, rounding is software's job
      4'hf: return {2'b10, `ADC_REG_SENS,      s.sens_code};
      default: return 18'h00000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [17:0] op;
    logic        last;
    op         = 18'h00000;
    last       = 1'b0;
    n          = q;
    n.wr       = 1'b0;
    n.rd       = 1'b0;
    n.sw_rdata = 8'h00;

    if (sw_rd) begin
      case (sw_addr)
        `ADC_HST_SENS:   n.sw_rdata = q.sens_code;
        `ADC_HST_ODR:    n.sw_rdata = q.output_rate_field;
        `ADC_HST_STATUS: n.sw_rdata = {5'h00, q.done, q.refused, q.busy};
        `ADC_HST_CONFIG: n.sw_rdata = q.cfg;
        default:         n.sw_rdata = 8'h00;
      endcase
    end

    case (q.st)
      ADC_IDLE: begin
        if (sw_wr) begin
          case (sw_addr)
            `ADC_HST_SENS: n.sens_code = sw_wdata;
            `ADC_HST_ODR:  n.output_rate_field       = sw_wdata;
            `ADC_HST_CMD: begin
              if (sw_wdata[`ADC_CMD_ENABLE] || sw_wdata[`ADC_CMD_DISABLE] ||
                  sw_wdata[`ADC_CMD_SENS]) begin
                n.enable  = sw_wdata[`ADC_CMD_ENABLE];
                n.step    = sw_wdata[`ADC_CMD_SENS] ? 4'hf : 4'h0;
                n.busy    = 1'b1;
                n.done    = 1'b0;
                n.refused = 1'b0;
                n.st      = ADC_ISSUE;
                op        = step_op(n, n.step);
                {n.wr, n.rd, n.addr, n.wdata} = op;
              end
            end
            default: ;
          endcase
        end
      end
      ADC_ISSUE: begin
        n.st = ADC_SETTLE;
      end
      ADC_SETTLE: begin
        last = (q.step == 4'he) || (q.step == 4'hf);
        if (q.step == 4'h5) begin
          n.cfg = link.rdata;
        end
        if (q.step == 4'h0 && q.enable &&
            link.rdata[`ADC_GAIN_LSB +: 3] == `ADC_GAIN_REDUCED) begin
          // refuse before touching anything
          n.refused = 1'b1;
          last      = 1'b1;
        end
        if (last) begin
          n.st   = ADC_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
        end else begin
          n.step = q.step + 4'h1;
          n.st   = ADC_ISSUE;
          op     = step_op(n, n.step);
          {n.wr, n.rd, n.addr, n.wdata} = op;
        end
      end
      default: n.st = ADC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      q    <= '0;
      q.st <= ADC_IDLE;
    end else begin
      q <= n;
    end
  end

  assign link.addr  = q.addr;
  assign link.wdata = q.wdata;
  assign link.wr    = q.wr;
  assign link.rd    = q.rd;
  assign sw_rdata   = q.sw_rdata;

endmodule
`default_nettype wire

/* verification/adc_link_properties.sv */
// checker on the register link between controller and device
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"
module adc_link_properties (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       algo_restart,
  input wire logic       acquisition_on
);
  // ----------------------------------------
  // shadow of page controls seen on the wire
  // ----------------------------------------
  logic [7:0] pa_q, dir_q, rate_q, cfg_q;
  logic       open_q, rdp_q;
  logic       data_wr, cfg_wr, rst_wr;
  assign data_wr = wr && addr == `ADC_REG_PAGE_DATA && open_q;
  assign cfg_wr  = data_wr && pa_q == `ADC_EMB_CONFIG;
  // restart needs page open, write direction and address 2ah all at once
  assign rst_wr  = data_wr && dir_q[1] && pa_q == `ADC_EMB_RESET
                   && wdata == `ADC_RESTART_VAL;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      {pa_q, dir_q, rate_q, cfg_q, open_q, rdp_q} <= '0;
    end else begin
      if (wr && addr == `ADC_REG_PAGE_ADDR)
        pa_q <= wdata;
      if (wr && addr == `ADC_REG_PAGE_DIR)
        dir_q <= wdata;
      if (wr && addr == `ADC_REG_RATE)
        rate_q <= wdata;
      if (wr && addr == `ADC_REG_PAGE_CTRL)
        open_q <= wdata[`ADC_OPEN_BIT];
      rdp_q <= rd && addr == `ADC_REG_PAGE_DATA && open_q
               && pa_q == `ADC_EMB_CONFIG;
      if (rdp_q)
        cfg_q <= rdata;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_ONE_STROBE: assert property (!(wr && rd))
    else $error("link read and write strobes together");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("link read data not zero outside answer cycle");
  AST_POWERED_DOWN: assert property (cfg_wr |-> rate_q[3:0] == 4'h0)
    else $error("config changed while acquiring");
  AST_WRITE_DIR: assert property (data_wr |-> dir_q == `ADC_DIR_WRITE_VAL)
    else $error("indirect write without write direction");
  AST_READ_DIR: assert property (rd && addr == `ADC_REG_PAGE_DATA && open_q
    |-> dir_q == `ADC_DIR_READ_VAL)
    else $error("indirect read without read direction");
  AST_CFG_VALUE: assert property (cfg_wr |-> wdata == (cfg_q | 8'h04)
    || wdata == (cfg_q & 8'hfb))
    else $error("config write is not a read-modify-write of bit 2");
  AST_RESTART_CAUSE: assert property (algo_restart |-> $past(rst_wr))
    else $error("algorithm restart without its write");
  AST_RESTART_ONE: assert property (rst_wr |=> algo_restart ##1 !algo_restart)
    else $error("algorithm restart not a single pulse");
  AST_RATE_CLOSED: assert property (wr && addr == `ADC_REG_RATE
    && wdata[3:0] != 4'h0 |-> !open_q && dir_q == 8'h00)
    else $error("acquisition restarted with page still open");
  AST_ACQ_TRACKS: assert property (wr && addr == `ADC_REG_RATE
    |=> acquisition_on == ($past(wdata[3:0]) != 4'h0))
    else $error("acquisition flag does not follow rate field");
  cover property (algo_restart);
  cover property (cfg_wr && wdata[2]);
  cover property (cfg_wr && !wdata[2]);
  cover property ($rose(acquisition_on));
endmodule
`default_nettype wire

/* verification/ambient_drift_compensation_tb_top.sv */
// self-checking bench: controller and device joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"
module ambient_drift_compensation_tb_top;
  logic        clock, resetn, sw_wr, sw_rd, sample_valid;
  logic [7:0]  sw_addr, sw_wdata, sw_rdata, sens_m, code;
  logic [15:0] raw, amb, algo_input, ref_m, last_m;
  logic        algo_restart, comp_active, acquisition_on;
  logic        rd_seen, smp_seen, en_m, acq_m, pend_m;
  logic [7:0]  exp8_q[$];
  logic [15:0] exp16_q[$];
  int          errors, check_count;
  adc_link_if link ();
  adc_host i_adc_host (.clock(clock), .resetn(resetn), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  adc_device i_adc_device (.clock(clock), .resetn(resetn), .link(link),
    .raw_object_sample(raw), .ambient_sample(amb),
    .sample_valid(sample_valid), .algo_input(algo_input),
    .algo_restart(algo_restart), .comp_active(comp_active),
    .acquisition_on(acquisition_on));
  adc_link_properties i_adc_link_properties (.clock(clock),
    .resetn(resetn), .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
    .rd(link.rd), .rdata(link.rdata), .algo_restart(algo_restart),
    .acquisition_on(acquisition_on));
  // ----------------------------------------
  // compare, bus and sample tasks
  // ----------------------------------------
  task automatic cmp_byte(string what, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_word(string what, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic sw_write(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    sw_addr <= a;
    sw_rd <= 1'b1;
    exp8_q.push_back(e);
    @(posedge clock);
    sw_rd <= 1'b0;
  endtask
  // an enable or disable sequence is 30 cycles, a sensitivity one 2; 32 leaves margin for the strobe
  task automatic command(logic [7:0] c);
    sw_write(`ADC_HST_CMD, c);
    repeat (32) @(posedge clock);
  endtask
  task automatic flags(logic c, logic a);
    cmp_word("comp_active", {15'h0, c}, {15'h0, comp_active});
    cmp_word("acquisition_on", {15'h0, a}, {15'h0, acquisition_on});
  endtask
  task automatic sample(logic [15:0] r, logic [15:0] a);
    longint v;
    @(posedge clock);
    raw <= r;
    amb <= a;
    sample_valid <= 1'b1;
    if (acq_m) begin
      if (pend_m) begin
        ref_m = a;
        pend_m = 1'b0;
      end
      v = longint'($signed(r));
      if (en_m)
        v += (16 * longint'($signed(sens_m)) + 2048)
             * (longint'($signed(a)) - longint'($signed(ref_m))) / 100;
      if (v > 32767)
        v = 32767;
      if (v < -32768)
        v = -32768;
      last_m = v[15:0];
    end
    exp16_q.push_back(last_m);
    @(posedge clock);
    sample_valid <= 1'b0;
  endtask
  // ambient kept near the reference so only part of the results saturate
  task automatic burst(int n);
    for (int i = 0; i < n; i++)
      sample(16'($urandom), 16'($urandom_range(6000)) - 16'd3000);
  endtask
  // ----------------------------------------
  // clock, monitor, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rd_seen)
      cmp_byte("sw_rdata", exp8_q.pop_front(), sw_rdata);
    if (smp_seen)
      cmp_word("algo_input", exp16_q.pop_front(), algo_input);
    rd_seen <= sw_rd && resetn;
    smp_seen <= sample_valid && resetn;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    wrap_up();
  end
  initial begin
    {sw_addr, sw_wdata, sw_wr, sw_rd, sample_valid, raw, amb} = '0;
    {resetn, en_m, acq_m, last_m, sens_m} = '0;
    pend_m = 1'b1;
    void'($urandom(32'hc127));
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    sw_read(`ADC_HST_STATUS, 8'h00);
    sw_read(8'h44, 8'h00);
    sample(16'h1234, 16'h0100);
    flags(1'b0, 1'b0);
    code = 8'($urandom);
    sw_write(`ADC_HST_SENS, code);
    command(8'h04);
    sens_m = code;
    sw_write(`ADC_HST_ODR, 8'h05);
    sw_write(`ADC_HST_CMD, 8'h01);
    sw_read(`ADC_HST_STATUS, 8'h01);
    sw_write(`ADC_HST_SENS, 8'h5a);
    repeat (30) @(posedge clock);
    {en_m, acq_m, pend_m} = 3'b111;
    sw_read(`ADC_HST_STATUS, 8'h04);
    sw_read(`ADC_HST_CONFIG, 8'h00);
    sw_read(`ADC_HST_SENS, code);
    flags(1'b1, 1'b1);
    sample(16'($urandom), 16'h0000);
    burst(12);
    command(8'h02);
    {en_m, pend_m} = 2'b01;
    sw_read(`ADC_HST_CONFIG, 8'h04);
    flags(1'b0, 1'b1);
    burst(4);
    sw_write(`ADC_HST_SENS, 8'h7f);
    command(8'h04);
    sens_m = 8'h7f;
    command(8'h03);
    {en_m, pend_m} = 2'b11;
    sw_read(`ADC_HST_CONFIG, 8'h00);
    sample(16'h0000, 16'h0000);
    sample(16'h7000, 16'd3000);
    sample(16'h8001, 16'hf448);
    burst(6);
    repeat (4) @(posedge clock);
    wrap_up();
  end
endmodule
`default_nettype wire
